// *** core/apsr_pkg.sv ***
package apsr_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  localparam logic [7:0] OFS_POWER_DOWN_CONTROL = 8'h13;
  localparam logic [7:0] OFS_RESERVED_SLOT = 8'h14;
  localparam logic [7:0] OFS_DEVICE_CONDITION = 8'h15;
  localparam logic [7:0] OFS_DECIMATION_INTEGER_LOW = 8'h16;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h21;

  localparam logic [7:0] RST_POWER_DOWN_CONTROL = 8'h00;
  localparam logic [7:0] RST_DEVICE_CONDITION = 8'h00;
  localparam logic [7:0] RST_DECIMATION_INTEGER_LOW = 8'h40;
  localparam logic [7:0] RST_IRQ_MASK = 8'h00;

  localparam int PD_CH0_BIT = 3;
  localparam int PD_CH3_BIT = 6;
  localparam int PD_REG_BIT = 1;
  localparam int PD_SLEEP_BIT = 0;
  localparam logic [7:0] PD_WRITE_MASK = 8'h7B;

  localparam int ST_DATA_CLOCK_MODE_BIT = 5;
  localparam int ST_DATA_CLOCK_DIR_BIT = 4;
  localparam int ST_ROLE_BIT = 3;
  localparam int ST_CLK_SRC_BIT = 2;
  localparam int ST_FUSE_BIT = 1;
  localparam int ST_LOCK_BIT = 0;

  localparam int IRQ_FUSE_BIT = 0;
  localparam int IRQ_LOCK_BIT = 1;
  localparam int IRQ_LOST_BIT = 2;
  localparam int IRQ_W = 3;

endpackage

// *** core/apsr_regs.sv ***
// The plain strobed port was chosen for this implementation.
module apsr_regs
  import apsr_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [DATA_W-1:0] regRdata,
  input wire logic dataClockModePin,
  input wire logic dataClockDirectionPin,
  input wire logic rolePin,
  input wire logic clockSourcePin,
  input wire logic fuseCorrected,
  input wire logic pllLocked,
  output logic [3:0] channelPowerOff,
  output logic regulatorPowerOff,
  output logic sleepMode,
  output logic [DATA_W-1:0] decimationIntegerLow,
  output logic irq
);

  logic [3:0] pinSync;
  logic dataClockModeFlag;
  logic dataClockDirectionFlag;
  logic roleFlag;
  logic clockSourceFlag;

  // Straps come from pins, so they pass the shared filtered synchroniser.
  apsr_sync #(
    .WIDTH(4)
  ) u_pin_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .asyncIn({dataClockModePin, dataClockDirectionPin, rolePin, clockSourcePin}),
    .syncOut(pinSync)
  );

  assign dataClockModeFlag = pinSync[3];
  assign dataClockDirectionFlag = pinSync[2];
  assign roleFlag = pinSync[1];
  assign clockSourceFlag = pinSync[0];

  logic [DATA_W-1:0] powerDown_q;
  logic [DATA_W-1:0] powerDown_d;
  logic [DATA_W-1:0] decim_q;
  logic [DATA_W-1:0] decim_d;
  logic fuseFlag_q;
  logic fuseFlag_d;
  logic lockSeen_q;
  logic lockSeen_d;
  logic [IRQ_W-1:0] irqStatus_q;
  logic [IRQ_W-1:0] irqStatus_d;
  logic [IRQ_W-1:0] irqMask_q;
  logic [IRQ_W-1:0] irqMask_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;

  logic wrPd;
  logic wrDec;
  logic wrMask;
  logic rdCond;
  logic rdIrq;
  logic lockNow;
  logic lockRise;
  logic lockFall;
  logic [DATA_W-1:0] condValue;

  assign wrPd = regWrite && (regAddr == OFS_POWER_DOWN_CONTROL);
  assign wrDec = regWrite && (regAddr == OFS_DECIMATION_INTEGER_LOW);
  assign wrMask = regWrite && (regAddr == OFS_IRQ_MASK);
  assign rdCond = regRead && (regAddr == OFS_DEVICE_CONDITION);
  assign rdIrq = regRead && (regAddr == OFS_IRQ_STATUS);

  // Lock is only meaningful in slave mode; master mode reports unlocked.
  assign lockNow = pllLocked && !roleFlag;
  assign lockRise = lockNow && !lockSeen_q;
  assign lockFall = !lockNow && lockSeen_q;

  always_comb
  begin
    condValue = '0;
    condValue[ST_DATA_CLOCK_MODE_BIT] = dataClockModeFlag;
    condValue[ST_DATA_CLOCK_DIR_BIT] = dataClockDirectionFlag;
    condValue[ST_ROLE_BIT] = roleFlag;
    condValue[ST_CLK_SRC_BIT] = clockSourceFlag;
    condValue[ST_FUSE_BIT] = fuseFlag_q;
    condValue[ST_LOCK_BIT] = lockSeen_q;
  end

  always_comb
  begin
    powerDown_d = powerDown_q;
    decim_d = decim_q;
    irqMask_d = irqMask_q;
    // Sleep gates only the analog side outside this bank, so registers keep working.
    if (wrPd)
    begin
      powerDown_d = regWdata & PD_WRITE_MASK;
    end
    if (wrDec)
    begin
      decim_d = regWdata;
    end
    if (wrMask)
    begin
      irqMask_d = regWdata[IRQ_W-1:0];
    end
  end

  // Control bytes change only on a decoded write, so sleep cannot disturb them.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      powerDown_q <= RST_POWER_DOWN_CONTROL;
      decim_q <= RST_DECIMATION_INTEGER_LOW;
      irqMask_q <= RST_IRQ_MASK[IRQ_W-1:0];
    end
    else
    begin
      powerDown_q <= powerDown_d;
      decim_q <= decim_d;
      irqMask_q <= irqMask_d;
    end
  end

  always_comb
  begin
    // A correction event in the read cycle survives so it is not lost.
    fuseFlag_d = fuseFlag_q;
    if (rdCond)
    begin
      fuseFlag_d = 1'b0;
    end
    if (fuseCorrected)
    begin
      fuseFlag_d = 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      fuseFlag_q <= 1'b0;
    end
    else
    begin
      fuseFlag_q <= fuseFlag_d;
    end
  end

  // The tracker holds last cycle's qualified lock, which also gives the edges.
  always_comb
  begin
    lockSeen_d = lockNow;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      lockSeen_q <= 1'b0;
    end
    else
    begin
      lockSeen_q <= lockSeen_d;
    end
  end

  always_comb
  begin
    irqStatus_d = irqStatus_q;
    if (rdIrq)
    begin
      irqStatus_d = '0;
    end
    if (fuseCorrected)
    begin
      irqStatus_d[IRQ_FUSE_BIT] = 1'b1;
    end
    if (lockRise)
    begin
      irqStatus_d[IRQ_LOCK_BIT] = 1'b1;
    end
    if (lockFall)
    begin
      irqStatus_d[IRQ_LOST_BIT] = 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      irqStatus_q <= '0;
    end
    else
    begin
      irqStatus_q <= irqStatus_d;
    end
  end

  always_comb
  begin
    rdata_d = '0;
    if (regRead)
    begin
      unique case (regAddr)
        OFS_POWER_DOWN_CONTROL: rdata_d = powerDown_q;
        OFS_RESERVED_SLOT: rdata_d = '0;
        OFS_DEVICE_CONDITION: rdata_d = condValue;
        OFS_DECIMATION_INTEGER_LOW: rdata_d = decim_q;
        OFS_IRQ_STATUS: rdata_d = {{(DATA_W-IRQ_W){1'b0}}, irqStatus_q};
        OFS_IRQ_MASK: rdata_d = {{(DATA_W-IRQ_W){1'b0}}, irqMask_q};
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      rdata_q <= '0;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  assign regRdata = rdata_q;
  assign channelPowerOff = powerDown_q[PD_CH3_BIT:PD_CH0_BIT];
  assign regulatorPowerOff = powerDown_q[PD_REG_BIT];
  assign sleepMode = powerDown_q[PD_SLEEP_BIT];
  assign decimationIntegerLow = decim_q;
  assign irq = |(irqStatus_q & irqMask_q);

  pd_write_a: assert property (@(posedge mclk) disable iff (sys_rst)
    wrPd |=> channelPowerOff == $past(regWdata[PD_CH3_BIT:PD_CH0_BIT]))
    else $error("Channel power bits did not take the written value.");

  reg_off_a: assert property (@(posedge mclk) disable iff (sys_rst)
    wrPd |=> regulatorPowerOff == $past(regWdata[PD_REG_BIT]))
    else $error("Regulator power bit did not take the written value.");

  sleep_keeps_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (sleepMode && !wrDec) |=> decim_q == $past(decim_q))
    else $error("Decimation byte changed during sleep without a write.");

  role_bit_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (regRead && regAddr == OFS_DEVICE_CONDITION) |=> regRdata[ST_ROLE_BIT] == $past(roleFlag))
    else $error("Role bit read back wrong.");

  fuse_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (rdCond && !fuseCorrected) |=> !fuseFlag_q)
    else $error("Fuse flag not cleared by status read.");

  fuse_set_a: assert property (@(posedge mclk) disable iff (sys_rst)
    fuseCorrected |=> fuseFlag_q ##0 irqStatus_q[IRQ_FUSE_BIT])
    else $error("Fuse event lost.");

  lock_slave_a: assert property (@(posedge mclk) disable iff (sys_rst)
    roleFlag ##1 roleFlag |-> !lockSeen_q)
    else $error("Lock reported outside slave mode.");

  decim_rst_a: assert property (@(posedge mclk)
    sys_rst |=> decimationIntegerLow == RST_DECIMATION_INTEGER_LOW)
    else $error("Decimation byte reset value wrong.");

  rsvd_zero_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (regRead && regAddr == OFS_RESERVED_SLOT) |=> regRdata == '0)
    else $error("Reserved register read nonzero.");

  pd_rsvd_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (regRead && regAddr == OFS_POWER_DOWN_CONTROL) |=> (regRdata & ~PD_WRITE_MASK) == '0)
    else $error("Reserved power-down bits read nonzero.");

  pd_reset_a: assert property (@(posedge mclk)
    sys_rst |=> (channelPowerOff == '0) && !regulatorPowerOff && !sleepMode)
    else $error("Power-down outputs not cleared by reset.");

  mode_bit_a: assert property (@(posedge mclk) disable iff (sys_rst)
    rdCond |=> regRdata[ST_DATA_CLOCK_MODE_BIT] == $past(dataClockModeFlag))
    else $error("Data clock mode bit read back wrong.");

  dir_bit_a: assert property (@(posedge mclk) disable iff (sys_rst)
    rdCond |=> regRdata[ST_DATA_CLOCK_DIR_BIT] == $past(dataClockDirectionFlag))
    else $error("Data clock direction bit read back wrong.");

  clk_src_a: assert property (@(posedge mclk) disable iff (sys_rst)
    rdCond |=> regRdata[ST_CLK_SRC_BIT] == $past(clockSourceFlag))
    else $error("Clock source bit read back wrong.");

  fuse_read_a: assert property (@(posedge mclk) disable iff (sys_rst)
    rdCond |=> regRdata[ST_FUSE_BIT] == $past(fuseFlag_q))
    else $error("Fuse bit read did not show the value before clearing.");

  lock_track_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (pllLocked && !roleFlag) |=> lockSeen_q)
    else $error("Lock in slave mode not reported.");

  lock_drop_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !pllLocked |=> !lockSeen_q)
    else $error("Lock reported while the PLL is unlocked.");

  decim_write_a: assert property (@(posedge mclk) disable iff (sys_rst)
    wrDec |=> decimationIntegerLow == $past(regWdata))
    else $error("Decimation byte did not take the written value.");

  // The two top status bits have no source and must never leak anything.
  cond_rsvd_a: assert property (@(posedge mclk) disable iff (sys_rst)
    rdCond |=> regRdata[DATA_W-1:ST_DATA_CLOCK_MODE_BIT+1] == '0)
    else $error("Reserved status bits read nonzero.");

endmodule

// *** core/apsr_sync.sv ***
module apsr_sync
  import apsr_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] stage2_q;
  logic [WIDTH-1:0] stage3_q;
  logic [WIDTH-1:0] out_q;
  logic [WIDTH-1:0] out_d;

  // A zero-width synchroniser has nothing to carry.
  if (WIDTH < 1)
  begin
    $error("Synchroniser width must be at least one.");
  end

  always_comb
  begin
    out_d = out_q;
    for (int i = 0; i < WIDTH; i++)
    begin
      // A change is accepted only once two late stages agree, filtering single glitches.
      if (stage2_q[i] == stage3_q[i])
      begin
        out_d[i] = stage2_q[i];
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      meta_q <= '0;
      stage2_q <= '0;
      stage3_q <= '0;
      out_q <= '0;
    end
    else
    begin
      meta_q <= asyncIn;
      stage2_q <= meta_q;
      stage3_q <= stage2_q;
      out_q <= out_d;
    end
  end

  assign syncOut = out_q;

endmodule

// *** testbench/adc_power_status_regs_test.sv ***
module adc_power_status_regs_test
  import apsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, sys_rst = 1, regWrite = 0, regRead = 0, fuseCorrected = 0, pllLocked = 0;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, decimationIntegerLow, v;
  logic [3:0] pins = 4'h0, channelPowerOff;
  logic regulatorPowerOff, sleepMode, irq, rdPend = 0;
  logic [8:0] notes[$];
  // The monitor keeps its own note so it never overwrites a stimulus value.
  logic [8:0] note;
  int num_errors = 0, cmp_count = 0, cyc = 0, seed = 32'hB9D2E437;
  apsr_regs u_dut (.mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .dataClockModePin(pins[3]), .dataClockDirectionPin(pins[2]), .rolePin(pins[1]),
    .clockSourcePin(pins[0]), .fuseCorrected(fuseCorrected), .pllLocked(pllLocked),
    .channelPowerOff(channelPowerOff), .regulatorPowerOff(regulatorPowerOff),
    .sleepMode(sleepMode), .decimationIntegerLow(decimationIntegerLow), .irq(irq));
  initial
  begin
    forever #2 mclk = ~mclk;
  end
  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    cmp_count++;
    if (s !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic nap(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask
  // Reads that carry no note still pass through the queue so that order stays aligned.
  task automatic rd(logic [7:0] a, logic [7:0] e, logic c);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    notes.push_back({c, e});
    @(posedge mclk);
    regRead <= 1'b0;
  endtask
  task automatic pulse();
    @(posedge mclk);
    fuseCorrected <= 1'b1;
    @(posedge mclk);
    fuseCorrected <= 1'b0;
  endtask
  function automatic logic [7:0] stat(logic f);
    return {2'b00, pins, f, pllLocked & ~pins[1]};
  endfunction
  always @(posedge mclk)
  begin
    if (rdPend && notes.size() > 0)
    begin
      note = notes.pop_front();
      if (note[8])
      begin
        chk("regRdata", note[7:0], regRdata);
      end
    end
    rdPend <= regRead;
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    if (num_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    nap(1);
    chk("decimationIntegerLow", RST_DECIMATION_INTEGER_LOW, decimationIntegerLow);
    chk("powerOff", 8'h00, {channelPowerOff, 2'b00, regulatorPowerOff, sleepMode});
    rd(OFS_POWER_DOWN_CONTROL, 8'h00, 1);
    rd(OFS_RESERVED_SLOT, 8'h00, 1);
    rd(OFS_DEVICE_CONDITION, 8'h00, 1);
    rd(OFS_DECIMATION_INTEGER_LOW, 8'h40, 1);
    rd(OFS_IRQ_MASK, 8'h00, 1);
    for (int i = 0; i < 6; i++)
    begin
      v = (i == 0) ? 8'hFF : 8'($random(seed));
      wr(OFS_POWER_DOWN_CONTROL, v);
      nap(1);
      chk("channelPowerOff", v[6:3], channelPowerOff);
      chk("regulatorPowerOff", v[1], regulatorPowerOff);
      chk("sleepMode", v[0], sleepMode);
      rd(OFS_POWER_DOWN_CONTROL, v & 8'h7B, 1);
      v = 8'($random(seed));
      wr(OFS_DECIMATION_INTEGER_LOW, v);
      wr(OFS_POWER_DOWN_CONTROL, 8'h01);
      nap(1);
      chk("decimationIntegerLow", v, decimationIntegerLow);
      rd(OFS_DECIMATION_INTEGER_LOW, v, 1);
    end
    wr(OFS_RESERVED_SLOT, 8'hFF);
    wr(OFS_DEVICE_CONDITION, 8'hFF);
    rd(OFS_RESERVED_SLOT, 8'h00, 1);
    rd(OFS_DEVICE_CONDITION, 8'h00, 1);
    rd(8'h3C, 8'h00, 1);
    for (int i = 0; i < 16; i++)
    begin
      @(posedge mclk);
      pins <= i[3:0];
      pllLocked <= 1'($random(seed));
      nap(6);
      rd(OFS_DEVICE_CONDITION, stat(0), 1);
    end
    rd(OFS_IRQ_STATUS, 8'h00, 0);
    wr(OFS_IRQ_MASK, 8'h01);
    pulse();
    nap(3);
    chk("irq", 8'h01, irq);
    rd(OFS_DEVICE_CONDITION, stat(1), 1);
    rd(OFS_DEVICE_CONDITION, stat(0), 1);
    rd(OFS_IRQ_STATUS, 8'h01, 1);
    nap(2);
    chk("irq", 8'h00, irq);
    wr(OFS_IRQ_MASK, 8'h00);
    pulse();
    nap(3);
    chk("irq", 8'h00, irq);
    @(posedge mclk);
    pins <= 4'h0;
    pllLocked <= 1'b0;
    nap(6);
    rd(OFS_IRQ_STATUS, 8'h00, 0);
    rd(OFS_DEVICE_CONDITION, 8'h00, 0);
    wr(OFS_IRQ_MASK, 8'h06);
    @(posedge mclk);
    pllLocked <= 1'b1;
    nap(4);
    chk("irq", 8'h01, irq);
    rd(OFS_DEVICE_CONDITION, 8'h01, 1);
    rd(OFS_IRQ_STATUS, 8'h02, 1);
    @(posedge mclk);
    pllLocked <= 1'b0;
    nap(4);
    rd(OFS_IRQ_STATUS, 8'h04, 1);
    nap(3);
    chk("irq", 8'h00, irq);
    tally_and_finish();
  end
endmodule
